// file: design/exception_reset_sequencer.sv
// Exception arbiter and reset sequencer with a Wishbone register slave
`timescale 1ns/100ps
`default_nettype none
`include "exception_reset_consts.svh"

module exception_reset_sequencer #(
	parameter int PORT_PINS = 48,
	parameter bit ADVANCED = 1'b1
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic chip_reset_input_low,
	input wire logic watchdog_overflow,
	input wire ers_pkg::cpu_report_s cpu_report,
	input wire ers_pkg::int_request_s int_request,
	input wire logic vec_fetch_ack,
	input wire logic [23:0] vec_fetch_data,
	output logic vec_fetch_req,
	output logic [15:0] vec_fetch_addr,
	output ers_pkg::exc_request_s exc_request,
	output logic cpu_hold,
	output logic module_init,
	output logic pc_load,
	output logic [23:0] pc_value,
	output logic trace_flag,
	output logic ccr_mask,
	output logic exr_mask,
	output logic [1:0] int_mode,
	output logic ext_bus_enable,
	output logic [PORT_PINS-1:0] port_gpio_mode,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);

	// ------------------------------------------------------------------
	// Reset pin synchroniser and vector maps
	// ------------------------------------------------------------------
	ers_pkg::seq_regs_s st_reg;
	ers_pkg::seq_regs_s st_next;
	logic res_high;
	logic [6:0] sel_vec;
	logic [15:0] sel_addr;
	logic int_legal;
	logic mode2;
	logic accept;
	logic trace_now;
	logic direct_now;
	logic trap_now;
	logic int_ok;

	// Pin is asynchronous to the core clock
	level_sync2 u_res_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.async_in(chip_reset_input_low),
		.sync_out(res_high)
	);
	vector_address_map u_sel_map (
		.vector(sel_vec),
		.advanced(ADVANCED),
		.addr(sel_addr),
		.legal()
	);
	vector_address_map u_int_map (
		.vector(int_request.vector),
		.advanced(ADVANCED),
		.addr(),
		.legal(int_legal)
	);

	// ------------------------------------------------------------------
	// Arbitration terms
	// ------------------------------------------------------------------
	// Mode 2 only for the exact code 10
	assign mode2 = st_reg.flags.mode_hi & ~st_reg.flags.mode_lo;
	assign accept = (st_reg.state == ers_pkg::ST_RUN)
		& (cpu_report.instr_done | cpu_report.exc_done);
	// Trace is raised per completed step, never after a return
	assign trace_now = st_reg.pend.trace | (accept & st_reg.flags.trace & mode2
		& ~(cpu_report.instr_done & (cpu_report.kind == ers_pkg::INS_RETURN)));
	assign direct_now = st_reg.pend.direct
		| ((st_reg.state == ers_pkg::ST_RUN) & cpu_report.direct_transition);
	assign trap_now = st_reg.pend.trap
		| ((st_reg.state == ers_pkg::ST_RUN) & cpu_report.trap);
	// Interrupts are sampled only at clean acceptance points
	assign int_ok = accept & int_request.valid & int_legal & ~st_reg.first_block
		& ~(cpu_report.instr_done & ((cpu_report.kind == ers_pkg::INS_CCR_LOGIC)
		| (cpu_report.kind == ers_pkg::INS_LOAD_CTRL)));
	// Fixed priority picks the winning vector number
	always_comb
	begin
		if (trace_now)
			sel_vec = `ERS_VEC_TRACE;
		else if (direct_now)
			sel_vec = `ERS_VEC_DIRECT;
		else if (int_ok)
			sel_vec = int_request.vector;
		else if (trap_now)
			sel_vec = `ERS_VEC_TRAP_BASE | {5'h00, st_reg.pend.trap ? st_reg.pend.trap_op
				: cpu_report.trap_operand};
		else
			sel_vec = `ERS_VEC_RESET;
	end

	// ------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------
	// Bus first, hardware after, so hardware events win
	always_comb
	begin
		st_next = st_reg;
		st_next.exc.take = 1'b0;
		st_next.module_init = 1'b0;
		st_next.pc_load = 1'b0;
		st_next.wb_ack = 1'b0;

		// Single-cycle classic slave, ack dropped after one cycle
		if (wb_cyc_i && wb_stb_i && !st_reg.wb_ack)
		begin
			st_next.wb_ack = 1'b1;
			st_next.wb_dat = 32'h0000_0000;
			unique case (wb_adr_i)
				`ERS_CTRL_OFS:
				begin
					st_next.wb_dat[4:0] = {st_reg.flags.exr_mask, st_reg.flags.ccr_mask,
						st_reg.flags.trace, st_reg.flags.mode_hi, st_reg.flags.mode_lo};
					if (wb_we_i && wb_sel_i[0])
					begin
						st_next.flags.trace = wb_dat_i[`ERS_CTRL_TRACE];
						st_next.flags.ccr_mask = wb_dat_i[`ERS_CTRL_CCR_MASK];
						st_next.flags.exr_mask = wb_dat_i[`ERS_CTRL_EXR_MASK];
						// Prohibited codes leave the mode untouched
						if (!wb_dat_i[`ERS_CTRL_MODE_LO])
							st_next.flags.mode_hi = wb_dat_i[`ERS_CTRL_MODE_HI];
					end
				end
				`ERS_STATUS_OFS:
				begin
					st_next.wb_dat[`ERS_STAT_STATE_LSB +: 2] = st_reg.state;
					st_next.wb_dat[`ERS_STAT_FIRST_BLOCK] = st_reg.first_block;
					st_next.wb_dat[`ERS_STAT_PEND_LSB +: 3] =
						{st_reg.pend.trap, st_reg.pend.direct, st_reg.pend.trace};
					st_next.wb_dat[`ERS_STAT_SHORT_RESET] = st_reg.short_reset;
				end
				`ERS_LAST_EXC_OFS:
					st_next.wb_dat[25:0] = {st_reg.exc.kind, st_reg.exc.vector, st_reg.exc.addr};
				`ERS_PC_OFS:
					st_next.wb_dat[23:0] = st_reg.pc_value;
				default:
					st_next.wb_dat = 32'h0000_0000;
			endcase
		end

		// Length of the last low pulse, saturating
		if (!res_high)
		begin
			if (st_reg.low_cnt < 5'(`ERS_RESET_MIN_CYC))
				st_next.low_cnt = st_reg.low_cnt + 5'h01;
		end

		unique case (st_reg.state)
			ers_pkg::ST_HOLD:
			begin
				// Short pulses are flagged, the far end owns the width
				if (res_high)
				begin
					st_next.state = ers_pkg::ST_INIT;
					st_next.short_reset = st_reg.low_cnt < 5'(`ERS_RESET_MIN_CYC);
					st_next.low_cnt = 5'h00;
				end
			end
			ers_pkg::ST_INIT:
			begin
				st_next.state = ers_pkg::ST_FETCH;
				st_next.module_init = 1'b1;
				st_next.flags.trace = `ERS_TRACE_RST;
				st_next.flags.ccr_mask = `ERS_MASK_RST;
				st_next.flags.exr_mask = `ERS_MASK_RST;
				{st_next.flags.mode_hi, st_next.flags.mode_lo} = `ERS_MODE_RST;
				st_next.pend = '0;
				st_next.first_block = 1'b1;
				st_next.exc.take = 1'b1;
				st_next.exc.kind = ers_pkg::EXC_RESET;
				st_next.exc.vector = `ERS_VEC_RESET;
				st_next.exc.addr = 16'h0000;
			end
			ers_pkg::ST_FETCH:
			begin
				// Reset vector entry becomes the program counter
				if (vec_fetch_ack)
				begin
					st_next.state = ers_pkg::ST_RUN;
					st_next.pc_load = 1'b1;
					st_next.pc_value = vec_fetch_data;
				end
			end
			ers_pkg::ST_RUN:
			begin
				// Pending bits copy the live terms; the take clears the winner's bit, none for an interrupt
				st_next.pend.trace = trace_now;
				st_next.pend.direct = direct_now;
				st_next.pend.trap = trap_now;
				if (cpu_report.trap && !st_reg.pend.trap)
					st_next.pend.trap_op = cpu_report.trap_operand;
				if (cpu_report.instr_done)
					st_next.first_block = 1'b0;
				if (accept && (trace_now || direct_now || int_ok || trap_now))
				begin
					st_next.exc.take = 1'b1;
					st_next.exc.vector = sel_vec;
					st_next.exc.addr = sel_addr;
					st_next.flags.ccr_mask = 1'b1;
					if (mode2)
						st_next.flags.trace = 1'b0;
					// Losers keep their pending bits
					if (trace_now)
					begin
						st_next.exc.kind = ers_pkg::EXC_TRACE;
						st_next.pend.trace = 1'b0;
					end
					else if (direct_now)
					begin
						st_next.exc.kind = ers_pkg::EXC_DIRECT;
						st_next.pend.direct = 1'b0;
					end
					else if (int_ok)
						st_next.exc.kind = ers_pkg::EXC_INT;
					else
					begin
						st_next.exc.kind = ers_pkg::EXC_TRAP;
						st_next.pend.trap = 1'b0;
					end
				end
			end
		endcase

		// Watchdog restarts handling without a pin pulse
		if (watchdog_overflow && res_high)
			st_next.state = ers_pkg::ST_INIT;

		// Pin low overrides the state machine, watchdog and pulses; the bus slave still answers
		if (!res_high)
		begin
			st_next.state = ers_pkg::ST_HOLD;
			st_next.exc.take = 1'b0;
			st_next.pc_load = 1'b0;
			st_next.module_init = 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	// Reset lands in hold; INIT then forces the architectural flags
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_reg <= '0;
			st_reg.state <= ers_pkg::ST_HOLD;
			st_reg.flags.ccr_mask <= `ERS_MASK_RST;
			st_reg.flags.exr_mask <= `ERS_MASK_RST;
			st_reg.first_block <= 1'b1;
		end
		else if (ce)
			st_reg <= st_next;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign vec_fetch_req = (st_reg.state == ers_pkg::ST_FETCH);
	assign vec_fetch_addr = 16'h0000;
	assign exc_request = st_reg.exc;
	assign cpu_hold = (st_reg.state != ers_pkg::ST_RUN);
	assign module_init = st_reg.module_init;
	assign pc_load = st_reg.pc_load;
	assign pc_value = st_reg.pc_value;
	assign trace_flag = st_reg.flags.trace;
	assign ccr_mask = st_reg.flags.ccr_mask;
	assign exr_mask = st_reg.flags.exr_mask;
	assign int_mode = {st_reg.flags.mode_hi, st_reg.flags.mode_lo};
	assign ext_bus_enable = 1'b0;
	assign port_gpio_mode = {PORT_PINS{1'b1}};
	assign wb_ack_o = st_reg.wb_ack;
	assign wb_dat_o = st_reg.wb_dat;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	a_reset_hold_state: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && !res_high) |=> (cpu_hold && !exc_request.take && !pc_load))
		else $error("processing continued while reset pin low");
	a_reset_release_start: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && res_high && st_reg.state == ers_pkg::ST_HOLD)
		|=> (st_reg.state == ers_pkg::ST_INIT))
		else $error("reset handling did not start on pin release");
	a_watchdog_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && res_high && watchdog_overflow) |=> (st_reg.state == ers_pkg::ST_INIT))
		else $error("watchdog overflow did not restart reset handling");
	a_init_flags_set: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && res_high && !watchdog_overflow && st_reg.state == ers_pkg::ST_INIT)
		|=> (!trace_flag && ccr_mask && exr_mask && int_mode == 2'b00 && module_init
		&& vec_fetch_req))
		else $error("reset initialisation values wrong");
	a_pc_from_vector: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && res_high && !watchdog_overflow && vec_fetch_req && vec_fetch_ack)
		|=> (pc_load && pc_value == $past(vec_fetch_data) && !cpu_hold))
		else $error("reset vector not loaded into program counter");
	a_vector_addr_map: assert property (@(posedge core_clk) disable iff (!rst_n)
		exc_request.take |-> (exc_request.addr == (ADVANCED
		? {7'h00, exc_request.vector, 2'b00} : {8'h00, exc_request.vector, 1'b0})))
		else $error("vector address does not match vector number");
	a_trace_wins_prio: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && res_high && !watchdog_overflow && accept && trace_now)
		|=> (exc_request.take && exc_request.kind == ers_pkg::EXC_TRACE
		&& exc_request.vector == `ERS_VEC_TRACE))
		else $error("trace not taken ahead of lower exceptions");
	a_loser_stays_pend: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && res_high && !watchdog_overflow && accept && !trace_now && !direct_now
		&& int_ok && trap_now) |=> (st_reg.pend.trap && exc_request.kind == ers_pkg::EXC_INT))
		else $error("trap lost when interrupt won arbitration");
	a_no_int_early: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && st_reg.first_block) |=> (exc_request.kind != ers_pkg::EXC_INT || !exc_request.take))
		else $error("interrupt taken before first instruction");
	a_no_trace_return: assert property (@(posedge core_clk) disable iff (!rst_n)
		(ce && accept && !st_reg.pend.trace && (!mode2 || (cpu_report.instr_done
		&& cpu_report.kind == ers_pkg::INS_RETURN)))
		|=> (exc_request.kind != ers_pkg::EXC_TRACE || !exc_request.take))
		else $error("trace taken outside mode 2 or after return");
	a_no_ext_access: assert property (@(posedge core_clk) disable iff (!rst_n)
		!ext_bus_enable)
		else $error("external address access enabled");

endmodule // exception_reset_sequencer

`default_nettype wire

// file: design/exception_reset_consts.svh
// Offsets, field positions, vector numbers, reset values and timing counts
`ifndef EXCEPTION_RESET_CONSTS_SVH
`define EXCEPTION_RESET_CONSTS_SVH

// Register byte offsets on the bus
`define ERS_CTRL_OFS 4'h0
`define ERS_STATUS_OFS 4'h4
`define ERS_LAST_EXC_OFS 4'h8
`define ERS_PC_OFS 4'hc

// Control register fields
`define ERS_CTRL_MODE_LO 0
`define ERS_CTRL_MODE_HI 1
`define ERS_CTRL_TRACE 2
`define ERS_CTRL_CCR_MASK 3
`define ERS_CTRL_EXR_MASK 4

// Status register fields
`define ERS_STAT_STATE_LSB 0
`define ERS_STAT_FIRST_BLOCK 2
`define ERS_STAT_PEND_LSB 3
`define ERS_STAT_SHORT_RESET 6

// Flag values forced by reset handling
`define ERS_TRACE_RST 1'b0
`define ERS_MASK_RST 1'b1
`define ERS_MODE_RST 2'h0

// Vector numbers
`define ERS_VEC_RESET 7'h00
`define ERS_VEC_MANUAL 7'h01
`define ERS_VEC_TRACE 7'h05
`define ERS_VEC_DIRECT 7'h06
`define ERS_VEC_NMI 7'h07
`define ERS_VEC_TRAP_BASE 7'h08
`define ERS_VEC_TRAP_LAST 7'h0b
`define ERS_VEC_IRQ_BASE 7'h10
`define ERS_VEC_IRQ_LAST 7'h15
`define ERS_VEC_INT_FIRST 7'h18
`define ERS_VEC_INT_LAST 7'h7f

// Timing: one state is one clock period
`define ERS_CLK_PERIOD_NS 10
`define ERS_STATE_PERIOD_NS 10
`define ERS_RESET_MIN_STATES 20
`define ERS_RESET_MIN_CYC \
	((`ERS_RESET_MIN_STATES * `ERS_STATE_PERIOD_NS + `ERS_CLK_PERIOD_NS - 1) / `ERS_CLK_PERIOD_NS)

`endif

// file: design/ers_pkg.sv
// Types shared by the exception and reset sequencer
package ers_pkg;

	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_INIT = 2'b01,
		ST_FETCH = 2'b10,
		ST_RUN = 2'b11
	} seq_state_e;

	typedef enum logic [2:0] {
		EXC_NONE = 3'b000,
		EXC_RESET = 3'b001,
		EXC_TRACE = 3'b010,
		EXC_DIRECT = 3'b011,
		EXC_INT = 3'b100,
		EXC_TRAP = 3'b101
	} exc_kind_e;

	typedef enum logic [1:0] {
		INS_PLAIN = 2'b00,
		INS_CCR_LOGIC = 2'b01,
		INS_LOAD_CTRL = 2'b10,
		INS_RETURN = 2'b11
	} instr_kind_e;

	typedef struct packed {
		logic instr_done;
		logic exc_done;
		instr_kind_e kind;
		logic trap;
		logic [1:0] trap_operand;
		logic direct_transition;
	} cpu_report_s;

	typedef struct packed {
		logic valid;
		logic [6:0] vector;
	} int_request_s;

	typedef struct packed {
		logic take;
		exc_kind_e kind;
		logic [6:0] vector;
		logic [15:0] addr;
	} exc_request_s;

	typedef struct packed {
		logic trace;
		logic ccr_mask;
		logic exr_mask;
		logic mode_hi;
		logic mode_lo;
	} flags_s;

	typedef struct packed {
		logic trace;
		logic direct;
		logic trap;
		logic [1:0] trap_op;
	} pend_s;

	typedef struct packed {
		logic meta;
		logic stable;
	} sync_regs_s;

	typedef struct packed {
		seq_state_e state;
		flags_s flags;
		pend_s pend;
		logic first_block;
		logic [4:0] low_cnt;
		logic short_reset;
		exc_request_s exc;
		logic module_init;
		logic pc_load;
		logic [23:0] pc_value;
		logic wb_ack;
		logic [31:0] wb_dat;
	} seq_regs_s;

endpackage

// file: design/level_sync2.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none

module level_sync2 (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic async_in,
	output logic sync_out
);

	ers_pkg::sync_regs_s st_reg;
	ers_pkg::sync_regs_s st_next;

	// First stage feeds only the second
	always_comb
	begin
		st_next.meta = async_in;
		st_next.stable = st_reg.meta;
	end

	// Resets low so the chip starts out held
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			st_reg <= '0;
		else if (ce)
			st_reg <= st_next;
	end

	assign sync_out = st_reg.stable;

endmodule // level_sync2

`default_nettype wire

// file: design/vector_address_map.sv
// Vector number to table address and legality check
`timescale 1ns/100ps
`default_nettype none
`include "exception_reset_consts.svh"

module vector_address_map (
	input wire logic [6:0] vector,
	input wire logic advanced,
	output logic [15:0] addr,
	output logic legal
);

	// Four-byte entries in advanced mode, two-byte in normal
	always_comb
	begin
		addr = advanced ? {7'h00, vector, 2'b00} : {8'h00, vector, 1'b0};
	end

	// Manual reset and reserved slots never pass as request vectors
	always_comb
	begin
		legal = (vector == `ERS_VEC_RESET) || (vector == `ERS_VEC_TRACE)
			|| (vector == `ERS_VEC_DIRECT) || (vector == `ERS_VEC_NMI)
			|| ((vector >= `ERS_VEC_TRAP_BASE) && (vector <= `ERS_VEC_TRAP_LAST))
			|| ((vector >= `ERS_VEC_IRQ_BASE) && (vector <= `ERS_VEC_IRQ_LAST))
			|| (vector >= `ERS_VEC_INT_FIRST);
	end

endmodule // vector_address_map

`default_nettype wire

// file: verification/vector_fetch_model.sv
// Far-side model answering the reset vector fetch
`timescale 1ns/100ps
`default_nettype none

module vector_fetch_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic vec_fetch_req,
	input wire logic [3:0] wait_cycles,
	input wire logic [23:0] vector,
	output logic vec_fetch_ack,
	output logic [23:0] vec_fetch_data
);
	logic [3:0] cnt;
	logic sent;

	// ----------------------------------------
	// Vector table read
	// ----------------------------------------
	// One answer per request; the data toggles when not answering so a stale value never matches
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 4'h0;
			sent <= 1'b0;
			vec_fetch_ack <= 1'b0;
			vec_fetch_data <= 24'h000000;
		end
		else
		begin
			vec_fetch_ack <= 1'b0;
			vec_fetch_data <= ~vec_fetch_data;
			if (!vec_fetch_req)
			begin
				cnt <= 4'h0;
				sent <= 1'b0;
			end
			else if (!sent && cnt == wait_cycles)
			begin
				vec_fetch_ack <= 1'b1;
				vec_fetch_data <= vector; // Reset vector entry
				sent <= 1'b1;
			end
			else
				cnt <= cnt + 4'h1; // Slow answer when wait_cycles is large
		end
	end
endmodule // vector_fetch_model
`default_nettype wire

// file: verification/exception_reset_sequencer_tb.sv
// Self-checking bench for the exception and reset sequencer
`timescale 1ns/100ps
`default_nettype none

module exception_reset_sequencer_tb;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic pin = 1'b0;
	logic wdog = 1'b0;
	ers_pkg::cpu_report_s cpu_report = '0;
	ers_pkg::int_request_s int_request = '0;
	logic ack, req, cpu_hold, module_init, pc_load, trace_flag, ccr_mask, exr_mask, ext_bus;
	logic [23:0] fdata, pc_value;
	logic [23:0] fvec = 24'h000000;
	logic [3:0] fwait = 4'h0;
	logic [15:0] faddr;
	ers_pkg::exc_request_s exc_request;
	ers_pkg::exc_request_s e;
	logic [1:0] int_mode;
	logic [47:0] gpio;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic wack;
	int fails = 0;
	int n_tests = 0;
	logic [1:0] op = 2'h0;
	logic [6:0] v;

	// ----------------------------------------
	// Clock, design and partner
	// ----------------------------------------
	always #5 core_clk = ~core_clk;

	exception_reset_sequencer exception_reset_sequencer_inst (.core_clk(core_clk), .rst_n(rst_n),
		.ce(1'b1), .chip_reset_input_low(pin), .watchdog_overflow(wdog), .cpu_report(cpu_report),
		.int_request(int_request), .vec_fetch_ack(ack), .vec_fetch_data(fdata),
		.vec_fetch_req(req), .vec_fetch_addr(faddr), .exc_request(exc_request),
		.cpu_hold(cpu_hold), .module_init(module_init), .pc_load(pc_load), .pc_value(pc_value),
		.trace_flag(trace_flag), .ccr_mask(ccr_mask), .exr_mask(exr_mask), .int_mode(int_mode),
		.ext_bus_enable(ext_bus), .port_gpio_mode(gpio), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(wack));

	vector_fetch_model vector_fetch_model_inst (.core_clk(core_clk), .rst_n(rst_n),
		.vec_fetch_req(req), .wait_cycles(fwait), .vector(fvec), .vec_fetch_ack(ack),
		.vec_fetch_data(fdata));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic final_report();
		if (fails == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Classic cycle: hold until ack, then release for at least one cycle
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (wack !== 1'b1 && n < 50);
		q = rdat;
		if (n >= 50)
			fails++;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	function automatic ers_pkg::cpu_report_s mk(ers_pkg::instr_kind_e k, logic t, logic d);
		ers_pkg::cpu_report_s r;
		r = '0;
		r.instr_done = 1'b1;
		r.kind = k;
		r.trap = t;
		r.trap_operand = op;
		r.direct_transition = d;
		return r;
	endfunction

	// One acceptance point; sample the request the cycle after it
	task automatic acc(input ers_pkg::cpu_report_s r);
		@(posedge core_clk);
		cpu_report <= r;
		@(posedge core_clk);
		cpu_report <= '0;
		#1 e = exc_request;
	endtask

	// Expected take: vector address is four times the number in advanced mode
	task automatic expect_exc(input ers_pkg::exc_kind_e k, input logic [6:0] vn);
		chk("exc_request", {e.take, e.kind, e.vector, e.addr}, {1'b1, k, vn, {7'h00, vn, 2'b00}});
	endtask

	task automatic wait_boot();
		int n;
		logic mi;
		n = 0;
		mi = 1'b0;
		while (pc_load !== 1'b1 && n < 100)
		begin
			@(posedge core_clk);
			#1 n++;
			if (module_init === 1'b1)
				mi = 1'b1;
		end
		if (n >= 100)
			fails++;
		chk("module_init", mi, 1'b1);
		chk("pc_value", pc_value, fvec);
		chk("cpu_hold", cpu_hold, 1'b0);
		chk("reset_exc", {exc_request.kind, exc_request.vector, exc_request.addr},
			{ers_pkg::EXC_RESET, 7'h00, 16'h0000});
		chk("flags", {trace_flag, ccr_mask, exr_mask, int_mode}, 5'b01100);
	endtask

	// Random maskable vector from the external and internal ranges
	task automatic raise_int();
		v = ($urandom % 2) ? 7'(16 + $urandom % 6) : 7'(24 + $urandom % 104);
		wb(1'b0 ^ 1'b1, 4'h0, 32'h0); // Masks and trace cleared; int_ok ignores the masks
		int_request <= '{valid: 1'b1, vector: v};
	endtask

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial
	begin
		#100us;
		fails++;
		final_report();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		void'($urandom(52));
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (13) @(posedge core_clk); // Pin low 25 cycles, power-up hold scaled down
		#1 chk("hold", cpu_hold, 1'b1);
		chk("flags_hold", {trace_flag, ccr_mask, exr_mask, int_mode}, 5'b01100);
		chk("ext_bus", ext_bus, 1'b0);
		chk("gpio", gpio[31:0] & gpio[47:16], 32'hffffffff);
		fvec = 24'($urandom);
		pin <= 1'b1;
		wait_boot();
		wb(1'b0, 4'hc, 32'h0);
		chk("pc_reg", q, {8'h00, fvec});
		wb(1'b0, 4'h4, 32'h0);
		chk("status_run", q[5:0], 6'b000111);
		raise_int();
		acc(mk(ers_pkg::INS_PLAIN, 1'b0, 1'b0));
		chk("first_block", e.take, 1'b0);
		acc(mk(ers_pkg::INS_PLAIN, 1'b0, 1'b0));
		expect_exc(ers_pkg::EXC_INT, v);
		int_request <= '0;
		raise_int();
		acc(mk(ers_pkg::INS_CCR_LOGIC, 1'b0, 1'b0));
		chk("no_sample_ccr", e.take, 1'b0);
		acc(mk(ers_pkg::INS_LOAD_CTRL, 1'b0, 1'b0));
		chk("no_sample_ldc", e.take, 1'b0);
		acc(mk(ers_pkg::INS_PLAIN, 1'b0, 1'b0));
		expect_exc(ers_pkg::EXC_INT, v);
		// Manual-reset slot is not an interrupt source here
		int_request <= '{valid: 1'b1, vector: 7'h01};
		acc(mk(ers_pkg::INS_PLAIN, 1'b0, 1'b0));
		chk("manual_vec", e.take, 1'b0);
		int_request <= '0;
		for (int i = 0; i < 4; i++)
		begin
			op = 2'(i);
			acc(mk(ers_pkg::INS_PLAIN, 1'b1, 1'b0));
			expect_exc(ers_pkg::EXC_TRAP, 7'(8 + i));
		end
		wb(1'b1, 4'h0, 32'h1);
		wb(1'b0, 4'h0, 32'h0);
		chk("mode_01", q[1:0], 2'b00);
		wb(1'b1, 4'h0, 32'h6);
		chk("mode_10", int_mode, 2'b10);
		wb(1'b0, 4'h0, 32'h0);
		chk("ctrl_read", q, 32'h6);
		wb(1'b0, 4'h2, 32'h0);
		chk("unmapped", q, 32'h0);
		// All sources at once: each loser is served at a later acceptance point
		op = 2'($urandom);
		int_request <= '{valid: 1'b1, vector: 7'h07};
		acc(mk(ers_pkg::INS_PLAIN, 1'b1, 1'b1));
		expect_exc(ers_pkg::EXC_TRACE, 7'h05);
		acc(mk(ers_pkg::INS_PLAIN, 1'b0, 1'b0));
		expect_exc(ers_pkg::EXC_DIRECT, 7'h06);
		acc(mk(ers_pkg::INS_PLAIN, 1'b0, 1'b0));
		expect_exc(ers_pkg::EXC_INT, 7'h07);
		int_request <= '0;
		acc(mk(ers_pkg::INS_PLAIN, 1'b0, 1'b0));
		expect_exc(ers_pkg::EXC_TRAP, 7'(8 + op));
		wb(1'b1, 4'h0, 32'h6);
		acc(mk(ers_pkg::INS_RETURN, 1'b0, 1'b0));
		chk("trace_after_return", e.take, 1'b0);
		wb(1'b1, 4'h0, 32'h4);
		acc(mk(ers_pkg::INS_PLAIN, 1'b0, 1'b0));
		chk("trace_mode0", e.take, 1'b0);
		// Watchdog overflow restarts with a slow vector answer
		fvec = 24'($urandom);
		fwait <= 4'h5;
		wdog <= 1'b1;
		@(posedge core_clk);
		wdog <= 1'b0;
		wait_boot();
		// Pin reset in mid-run, held past the minimum
		pin <= 1'b0;
		repeat (4) @(posedge core_clk);
		#1 chk("pin_hold", cpu_hold, 1'b1);
		acc(mk(ers_pkg::INS_PLAIN, 1'b1, 1'b0));
		chk("trap_in_reset", e.take, 1'b0);
		repeat (18) @(posedge core_clk);
		fvec = 24'($urandom);
		fwait <= 4'h2;
		pin <= 1'b1;
		wait_boot();
		final_report();
	end
endmodule // exception_reset_sequencer_tb
`default_nettype wire
